// ===== rtl/blp_params.svh
// Constants for the motor protection and brake logic: offsets, fields, timing
`ifndef BLP_PARAMS_SVH
`define BLP_PARAMS_SVH

// ==========================================================================
// Clock
`define BLP_CLK_HZ 10000000
`define BLP_CLK_PERIOD_NS 100

// ==========================================================================
// Lock timeout: 154 s per uF with a 0.01 uF part gives 1540 ms
`define BLP_LOCK_TIME_MS 1540
`define BLP_LOCK_CYC (`BLP_LOCK_TIME_MS * (`BLP_CLK_HZ / 1000))
// Short clear period, 0.5 s per uF with 0.01 uF; zero duty clears after 2x
`define BLP_SHORT_CLR_US 5000
`define BLP_ZERO_CLR_CYC (2 * `BLP_SHORT_CLR_US * (`BLP_CLK_HZ / 1000000))
// Stop mode held this long clears latched faults (least time, rounded up)
`define BLP_STOP_CLR_NS 10000
`define BLP_STOP_CLR_CYC ((`BLP_STOP_CLR_NS + `BLP_CLK_PERIOD_NS - 1) / `BLP_CLK_PERIOD_NS)
// Shoot-through guard interval (least time, rounded up)
`define BLP_GUARD_NS 1000
`define BLP_GUARD_CYC ((`BLP_GUARD_NS + `BLP_CLK_PERIOD_NS - 1) / `BLP_CLK_PERIOD_NS)
// Backward Hall steps (60 degrees each) that declare reversal
`define BLP_REV_STEPS 3
// Speed feedback noise filter length in samples
`define BLP_FILT_LEN 8

// ==========================================================================
// Register map
`define BLP_CTRL_OFS 4'h0
`define BLP_STAT_OFS 4'h4
`define BLP_CTRL_RST 8'h01
`define BLP_CTRL_LOCK_EN 0
`define BLP_CTRL_DIR_REV 1
`define BLP_STAT_LOCK 0
`define BLP_STAT_REVF 1
`define BLP_STAT_REVING 2
`define BLP_STAT_HALL_BAD 3
`define BLP_STAT_GUARD 4
`define BLP_STAT_BRAKE 5

`endif

// ===== rtl/blp_pkg.sv
// Types shared by the motor protection and brake logic
package blp_pkg;
   // Output drive mode, in priority order
   typedef enum logic [2:0] {
      blp_m_reset,
      blp_m_stop,
      blp_m_guard,
      blp_m_brake,
      blp_m_off,
      blp_m_run
   } blp_mode_t;
   typedef logic [2:0] blp_step_t;
endpackage : blp_pkg

// ===== rtl/blp_hall_if.sv
// Hall position bundle between the decoder and the protection core
`timescale 1ns/1ps
interface blp_hall_if;
   blp_pkg::blp_step_t step;
   logic valid;
   logic changed;
   logic fwd_step;
   logic back_step;
   logic dir_rev;
   modport mon (input dir_rev, output step, valid, changed, fwd_step,
      back_step);
   modport ctl (output dir_rev, input step, valid, changed, fwd_step,
      back_step);
endinterface : blp_hall_if

// ===== rtl/blp_hall_mon.sv
// Hall decoder: position step, validity, change and step direction
`timescale 1ns/1ps
module blp_hall_mon (
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic [2:0] hall,
   blp_hall_if.mon hb
);
   import blp_pkg::*;
   logic [2:0] prev_raw_ff;
   logic [2:0] prev_step_ff;
   logic prev_valid_ff;
   logic [3:0] diff;
   logic [2:0] delta;

   // ========================================================================
   // Gray sequence to step index; 000 and 111 are invalid
   always_comb
   begin
      hb.valid = 1'b1;
      case (hall)
         3'h1: hb.step = 3'h0;
         3'h3: hb.step = 3'h1;
         3'h2: hb.step = 3'h2;
         3'h6: hb.step = 3'h3;
         3'h4: hb.step = 3'h4;
         3'h5: hb.step = 3'h5;
         default:
         begin
            hb.step = 3'h0;
            hb.valid = 1'b0;
         end
      endcase
   end

   // Step distance modulo six; jumps of two or more are ignored as noise
   assign diff = {1'b0, hb.step} + 4'h6 - {1'b0, prev_step_ff};
   assign delta = (diff >= 4'h6) ? diff[2:0] - 3'h6 : diff[2:0];
   assign hb.changed = hall != prev_raw_ff;
   assign hb.fwd_step = hb.valid && prev_valid_ff &&
      (hb.dir_rev ? delta == 3'h5 : delta == 3'h1);
   assign hb.back_step = hb.valid && prev_valid_ff &&
      (hb.dir_rev ? delta == 3'h1 : delta == 3'h5);

   // Previous sample
   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         prev_raw_ff <= 3'h0;
         prev_step_ff <= 3'h0;
         prev_valid_ff <= 1'b0;
      end
      else
      begin
         prev_raw_ff <= hall;
         prev_step_ff <= hb.step;
         prev_valid_ff <= hb.valid;
      end
   end
endmodule : blp_hall_mon

// ===== rtl/blp_speed_filter.sv
// Noise filter for the speed feedback comparator result
`timescale 1ns/1ps
`include "blp_params.svh"
module blp_speed_filter #(
   parameter int FILT_LEN = `BLP_FILT_LEN
) (
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic speed_in,
   output logic speed_out
);
   import blp_pkg::*;
   localparam int CW = $clog2(FILT_LEN + 1);
   logic [CW-1:0] cnt_ff;
   logic out_ff;

   initial
   begin
      if (FILT_LEN < 2)
         $error("blp_speed_filter: FILT_LEN must be at least 2");
   end

   // ========================================================================
   // Follow the input only after it differs for FILT_LEN samples
   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         cnt_ff <= '0;
         out_ff <= 1'b0;
      end
      else if (speed_in == out_ff)
         cnt_ff <= '0;
      else if (cnt_ff == CW'(FILT_LEN - 1))
      begin
         cnt_ff <= '0;
         out_ff <= speed_in;
      end
      else
         cnt_ff <= cnt_ff + 1'b1;
   end
   assign speed_out = out_ff; // Same polarity as the raw input

   property p_filt_follow;
      @(posedge sys_clk) disable iff (!rst_b)
      $changed(out_ff) |-> $past(speed_in) == out_ff &&
         $past(speed_in, 2) == out_ff;
   endproperty
   a_filt_follow: assert property (p_filt_follow)
      else $error("filtered speed changed without a stable input");
endmodule : blp_speed_filter

// ===== rtl/blp_protect_top.sv
// Protection, brake and commutation logic of a three-phase motor predriver
// ==========================================================================
//
// The placing of the registers and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
`include "blp_params.svh"
module blp_protect_top #(
   parameter int LOCK_CYC = `BLP_LOCK_CYC,
   parameter int ZERO_CLR_CYC = `BLP_ZERO_CLR_CYC,
   parameter int STOP_CLR_CYC = `BLP_STOP_CLR_CYC,
   parameter int GUARD_CYC = `BLP_GUARD_CYC,
   parameter int FILT_LEN = `BLP_FILT_LEN
) (
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic hall_phase_1,
   input wire logic hall_phase_2,
   input wire logic hall_phase_3,
   input wire logic lock_timer_pin,
   input wire logic brake_n,
   input wire logic reverse_guard_select,
   input wire logic duty_pulse_in,
   input wire logic stop_req,
   input wire logic current_limit_req,
   input wire logic undervoltage_sense,
   input wire logic overtemp_threshold,
   input wire logic speed_amp_out,
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   output logic phase_u_high_drive,
   output logic phase_v_high_drive,
   output logic phase_w_high_drive,
   output logic phase_u_low_drive,
   output logic phase_v_low_drive,
   output logic phase_w_low_drive,
   output logic gate_drive_oe,
   output logic speed_filtered_out,
   output blp_pkg::blp_mode_t drive_mode
);
   import blp_pkg::*;

   localparam int LW = $clog2(LOCK_CYC + 1);
   localparam int ZW = $clog2(ZERO_CLR_CYC + 1);
   localparam int SW = $clog2(STOP_CLR_CYC + 1);
   localparam int GW = $clog2(GUARD_CYC + 1);

   initial
   begin
      if (LOCK_CYC < 2 || ZERO_CLR_CYC < 1 || STOP_CLR_CYC < 1)
         $error("blp_protect_top: timer counts too small");
      if (GUARD_CYC < 2)
         $error("blp_protect_top: GUARD_CYC must be at least 2");
   end

   // ========================================================================
   // Hall decoding and speed filter
   blp_hall_if hb ();
   logic [7:0] ctrl_ff;
   logic lock_en;
   logic rev_en;

   assign lock_en = ctrl_ff[`BLP_CTRL_LOCK_EN];
   assign hb.dir_rev = ctrl_ff[`BLP_CTRL_DIR_REV];
   assign rev_en = lock_en && !reverse_guard_select;

   blp_hall_mon u_hall (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .hall({hall_phase_3, hall_phase_2, hall_phase_1}),
      .hb(hb.mon)
   );

   blp_speed_filter #(.FILT_LEN(FILT_LEN)) u_speed (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .speed_in(speed_amp_out),
      .speed_out(speed_filtered_out)
   );

   // ========================================================================
   // Clear events and drive state
   logic logic_rst;
   logic braking;
   logic driving;
   logic [SW-1:0] stop_cnt_ff;
   logic [ZW-1:0] zero_cnt_ff;
   logic stop_clr;
   logic zero_clr;
   logic fault_clr;

   assign logic_rst = !lock_timer_pin;
   assign braking = !brake_n;
   assign driving = !stop_req && !braking;
   assign stop_clr = stop_req && stop_cnt_ff >= SW'(STOP_CLR_CYC - 1);
   // Undriven duty input reads high, i.e. off
   assign zero_clr = duty_pulse_in && zero_cnt_ff >= ZW'(ZERO_CLR_CYC);
   assign fault_clr = stop_clr || zero_clr;

   // Saturating hold-time counters for stop and zero duty
   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         stop_cnt_ff <= '0;
         zero_cnt_ff <= '0;
      end
      else
      begin
         if (logic_rst || !stop_req)
            stop_cnt_ff <= '0;
         else if (stop_cnt_ff != SW'(STOP_CLR_CYC))
            stop_cnt_ff <= stop_cnt_ff + 1'b1;
         if (logic_rst || !duty_pulse_in)
            zero_cnt_ff <= '0;
         else if (zero_cnt_ff != ZW'(ZERO_CLR_CYC))
            zero_cnt_ff <= zero_cnt_ff + 1'b1;
      end
   end

   // ========================================================================
   // Lock detection; braking holds the timer at zero
   logic [LW-1:0] lock_cnt_ff;
   logic lock_fault_ff;
   logic lock_set;

   // Trip once on reaching the end count; the timer then parks there, so
   // a clear during a stall holds until a fresh full timeout
   assign lock_set = lock_en && driving && !hb.changed &&
      lock_cnt_ff == LW'(LOCK_CYC - 2);

   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
         lock_cnt_ff <= '0;
      else if (logic_rst || !lock_en || !driving || hb.changed)
         lock_cnt_ff <= '0;
      else if (lock_cnt_ff != LW'(LOCK_CYC - 1))
         lock_cnt_ff <= lock_cnt_ff + 1'b1;
   end

   // Set wins over clear so a trip in the clearing cycle is kept
   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
         lock_fault_ff <= 1'b0;
      else if (logic_rst)
         lock_fault_ff <= 1'b0;
      else if (lock_set)
         lock_fault_ff <= 1'b1;
      else if (fault_clr)
         lock_fault_ff <= 1'b0;
   end

   // ========================================================================
   // Reverse rotation tracking and shutdown
   logic [1:0] back_cnt_ff;
   logic reversing_ff;
   logic [LW-1:0] rev_tmr_ff;
   logic rev_fault_ff;
   logic rev_set;

   // Tracked even while idle so a rotor already reversing is seen
   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         back_cnt_ff <= 2'h0;
         reversing_ff <= 1'b0;
      end
      else if (logic_rst || hb.fwd_step)
      begin
         back_cnt_ff <= 2'h0;
         reversing_ff <= 1'b0;
      end
      else if (hb.back_step)
      begin
         if (back_cnt_ff != 2'(`BLP_REV_STEPS))
            back_cnt_ff <= back_cnt_ff + 1'b1;
         if (back_cnt_ff == 2'(`BLP_REV_STEPS - 1))
            reversing_ff <= 1'b1;
      end
   end

   // Trips once as the timer reaches its end so zero duty can still clear
   assign rev_set = rev_en && driving && reversing_ff && !hb.fwd_step &&
      rev_tmr_ff == LW'(LOCK_CYC - 2);

   // Drive continues for one lock timeout before shutting off
   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
         rev_tmr_ff <= '0;
      else if (logic_rst || !driving || !reversing_ff || hb.fwd_step)
         rev_tmr_ff <= '0;
      else if (rev_tmr_ff != LW'(LOCK_CYC - 1))
         rev_tmr_ff <= rev_tmr_ff + 1'b1;
   end

   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
         rev_fault_ff <= 1'b0;
      else if (logic_rst)
         rev_fault_ff <= 1'b0;
      else if (rev_set)
         rev_fault_ff <= 1'b1;
      else if (fault_clr)
         rev_fault_ff <= 1'b0;
   end

   // ========================================================================
   // Shoot-through guard on brake or direction change
   logic brake_q_ff;
   logic dir_q_ff;
   logic [GW-1:0] guard_cnt_ff;
   logic guard_start;

   assign guard_start = brake_n != brake_q_ff || hb.dir_rev != dir_q_ff;

   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         brake_q_ff <= 1'b1;
         dir_q_ff <= 1'b0;
         guard_cnt_ff <= '0;
      end
      else
      begin
         brake_q_ff <= brake_n;
         dir_q_ff <= hb.dir_rev;
         if (logic_rst)
            guard_cnt_ff <= '0;
         else if (guard_start)
            guard_cnt_ff <= GW'(GUARD_CYC - 1);
         else if (guard_cnt_ff != '0)
            guard_cnt_ff <= guard_cnt_ff - 1'b1;
      end
   end

   // ========================================================================
   // Mode selection, highest priority first
   logic all_off;
   logic hi_block;
   blp_mode_t nxt_mode;

   // Zero duty under reverse protection stops all six unless braking
   assign all_off = !hb.valid || rev_fault_ff ||
      (rev_en && duty_pulse_in);
   // Current limit is only honoured outside braking
   assign hi_block = lock_fault_ff || (lock_en && overtemp_threshold) ||
      undervoltage_sense || current_limit_req;

   always_comb
   begin
      if (logic_rst)
         nxt_mode = blp_m_reset;
      else if (stop_req)
         nxt_mode = blp_m_stop;
      else if (guard_start || guard_cnt_ff != '0)
         nxt_mode = blp_m_guard;
      else if (braking)
         nxt_mode = blp_m_brake;
      else if (all_off)
         nxt_mode = blp_m_off;
      else
         nxt_mode = blp_m_run;
   end
   assign drive_mode = nxt_mode;

   // ========================================================================
   // Six-step commutation table, reverse uses the opposite step
   logic [2:0] cstep;
   logic [2:0] tbl_hi;
   logic [2:0] tbl_lo;

   assign cstep = hb.dir_rev ?
      ((hb.step >= 3'h3) ? hb.step - 3'h3 : hb.step + 3'h3) : hb.step;

   always_comb
   begin
      case (cstep)
         3'h0: {tbl_hi, tbl_lo} = {3'h1, 3'h2};
         3'h1: {tbl_hi, tbl_lo} = {3'h1, 3'h4};
         3'h2: {tbl_hi, tbl_lo} = {3'h2, 3'h4};
         3'h3: {tbl_hi, tbl_lo} = {3'h2, 3'h1};
         3'h4: {tbl_hi, tbl_lo} = {3'h4, 3'h1};
         3'h5: {tbl_hi, tbl_lo} = {3'h4, 3'h2};
         default: {tbl_hi, tbl_lo} = {3'h0, 3'h0};
      endcase
   end

   // ========================================================================
   // Registered gate drives; bit 0 is phase U, 1 is V, 2 is W
   logic [2:0] hi_ff;
   logic [2:0] lo_ff;
   logic oe_ff;

   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         hi_ff <= 3'h0;
         lo_ff <= 3'h0;
         oe_ff <= 1'b1;
      end
      else
      begin
         oe_ff <= nxt_mode != blp_m_stop;
         case (nxt_mode)
            blp_m_brake:
            begin
               hi_ff <= 3'h7;
               lo_ff <= 3'h0;
            end
            blp_m_run:
            begin
               hi_ff <= tbl_hi & {3{!duty_pulse_in && !hi_block}};
               lo_ff <= tbl_lo;
            end
            default:
            begin
               hi_ff <= 3'h0;
               lo_ff <= 3'h0;
            end
         endcase
      end
   end

   assign phase_u_high_drive = hi_ff[0];
   assign phase_v_high_drive = hi_ff[1];
   assign phase_w_high_drive = hi_ff[2];
   assign phase_u_low_drive = lo_ff[0];
   assign phase_v_low_drive = lo_ff[1];
   assign phase_w_low_drive = lo_ff[2];
   assign gate_drive_oe = oe_ff;

   // ========================================================================
   // Register port: control word and status, read data one cycle later
   logic [7:0] status;

   assign status = {2'h0, braking, guard_cnt_ff != '0, !hb.valid,
      reversing_ff, rev_fault_ff, lock_fault_ff};

   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
         ctrl_ff <= `BLP_CTRL_RST;
      else if (reg_wr && reg_addr == `BLP_CTRL_OFS)
         ctrl_ff <= {6'h00, reg_wdata[1:0]};
   end

   // Unmapped addresses read zero
   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
         reg_rdata <= 8'h00;
      else if (reg_rd && reg_addr == `BLP_CTRL_OFS)
         reg_rdata <= ctrl_ff;
      else if (reg_rd && reg_addr == `BLP_STAT_OFS)
         reg_rdata <= status;
      else
         reg_rdata <= 8'h00;
   end

   // ========================================================================
   // Checks
   property p_lock_trip;
      @(posedge sys_clk) disable iff (!rst_b)
      lock_en && driving && !logic_rst && !hb.changed &&
         lock_cnt_ff == LW'(LOCK_CYC - 2) |=> lock_fault_ff;
   endproperty
   a_lock_trip: assert property (p_lock_trip)
      else $error("lock timeout did not latch the lock fault");

   property p_lock_hi_off;
      @(posedge sys_clk) disable iff (!rst_b)
      lock_fault_ff && nxt_mode == blp_m_run |=> hi_ff == 3'h0;
   endproperty
   a_lock_hi_off: assert property (p_lock_hi_off)
      else $error("high side on during lock fault");

   property p_brake_no_lock;
      @(posedge sys_clk) disable iff (!rst_b)
      braking |=> lock_cnt_ff == '0;
   endproperty
   a_brake_no_lock: assert property (p_brake_no_lock)
      else $error("lock timer ran while braking");

   property p_stop_clear;
      @(posedge sys_clk) disable iff (!rst_b)
      stop_req [*8] ##1 stop_req && stop_cnt_ff >= SW'(STOP_CLR_CYC - 1) &&
         !lock_set |=> !lock_fault_ff;
   endproperty
   a_stop_clear: assert property (p_stop_clear)
      else $error("stop mode did not clear lock fault");

   property p_pin_reset;
      @(posedge sys_clk) disable iff (!rst_b)
      logic_rst |=> hi_ff == 3'h0 && lo_ff == 3'h0 && !lock_fault_ff &&
         !rev_fault_ff;
   endproperty
   a_pin_reset: assert property (p_pin_reset)
      else $error("drive or fault active with timer pin low");

   property p_rev_zero_off;
      @(posedge sys_clk) disable iff (!rst_b)
      rev_en && duty_pulse_in && nxt_mode != blp_m_brake &&
         nxt_mode != blp_m_stop |=> hi_ff == 3'h0 && lo_ff == 3'h0;
   endproperty
   a_rev_zero_off: assert property (p_rev_zero_off)
      else $error("outputs on at zero duty with reverse protection");

   property p_rev_fault_set;
      @(posedge sys_clk) disable iff (!rst_b)
      rev_set && !logic_rst |=> rev_fault_ff ##1 rev_fault_ff || fault_clr
         || $past(fault_clr) || logic_rst;
   endproperty
   a_rev_fault_set: assert property (p_rev_fault_set)
      else $error("persisting reversal did not shut off");

   property p_ot_off;
      @(posedge sys_clk) disable iff (!rst_b)
      overtemp_threshold && lock_en && nxt_mode == blp_m_run
         |=> hi_ff == 3'h0;
   endproperty
   a_ot_off: assert property (p_ot_off)
      else $error("high side on during over-temperature");

   property p_guard;
      @(posedge sys_clk) disable iff (!rst_b)
      $changed(brake_n) && !logic_rst && !stop_req
         |=> (hi_ff == 3'h0 && lo_ff == 3'h0) [*2];
   endproperty
   a_guard: assert property (p_guard)
      else $error("no guard interval at brake change");

   property p_brake;
      @(posedge sys_clk) disable iff (!rst_b)
      nxt_mode == blp_m_brake |=> hi_ff == 3'h7 && lo_ff == 3'h0;
   endproperty
   a_brake: assert property (p_brake)
      else $error("brake pattern wrong");

   property p_hall_bad;
      @(posedge sys_clk) disable iff (!rst_b)
      (hall_phase_1 == hall_phase_2 && hall_phase_2 == hall_phase_3) &&
         !braking |=> hi_ff == 3'h0 && lo_ff == 3'h0;
   endproperty
   a_hall_bad: assert property (p_hall_bad)
      else $error("outputs on with invalid Hall state");

   property p_stop_hiz;
      @(posedge sys_clk) disable iff (!rst_b)
      stop_req && !logic_rst |=> !oe_ff;
   endproperty
   a_stop_hiz: assert property (p_stop_hiz)
      else $error("gate drives enabled in stop mode");
endmodule : blp_protect_top

// ===== bench/blp_motor_model.sv
// Motor and Hall sensor model: rotor step to Hall code
`timescale 1ns/1ps
module blp_motor_model (
   input wire logic [2:0] pos,
   input wire logic bad,
   output logic [2:0] hall
);
   // ==========================================================
   // Hall code per rotor step; forcing all equal only on command
   always_comb
   begin
      case (pos)
         3'h0: hall = 3'h1;
         3'h1: hall = 3'h3;
         3'h2: hall = 3'h2;
         3'h3: hall = 3'h6;
         3'h4: hall = 3'h4;
         default: hall = 3'h5;
      endcase
      if (bad)
         hall = 3'h7;
   end
endmodule : blp_motor_model

// ===== bench/bldc_protection_brake_logic_tb_top.sv
// Self-checking bench for the protection and brake logic
`timescale 1ns/1ps
module bldc_protection_brake_logic_tb_top;
   import blp_pkg::*;
   logic sys_clk = 0;
   logic rst_b = 0;
   logic brake_n = 1;
   logic duty = 1;
   logic stp = 0;
   logic uv = 0;
   logic bad = 0;
   logic ltp = 1;
   logic rgs = 1;
   logic cl = 0;
   logic ot = 0;
   logic spd = 0;
   logic sfo;
   blp_mode_t dm;
   logic rd = 0;
   logic wr = 0;
   logic [2:0] pos = 0;
   logic [3:0] ra = 0;
   logic [7:0] wd = 0;
   logic [31:0] rs = 11;
   logic [7:0] rdat;
   logic [5:0] hl;
   logic [2:0] hall;
   logic oe;
   int num_errors = 0;
   int checked = 0;
   // ==========================================================
   // Clock and parts; short counts keep the run brief
   always #50 sys_clk = ~sys_clk;
   blp_motor_model i_blp_motor_model (.pos(pos), .bad(bad), .hall(hall));
   blp_protect_top #(.LOCK_CYC(50), .ZERO_CLR_CYC(20), .STOP_CLR_CYC(9),
      .GUARD_CYC(4), .FILT_LEN(4)) i_blp_protect_top (.sys_clk(sys_clk),
      .rst_b(rst_b), .hall_phase_1(hall[0]), .hall_phase_2(hall[1]),
      .hall_phase_3(hall[2]), .lock_timer_pin(ltp), .brake_n(brake_n),
      .reverse_guard_select(rgs), .duty_pulse_in(duty), .stop_req(stp),
      .current_limit_req(cl), .undervoltage_sense(uv),
      .overtemp_threshold(ot), .speed_amp_out(spd), .reg_addr(ra),
      .reg_wdata(wd), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdat),
      .phase_u_high_drive(hl[3]), .phase_v_high_drive(hl[4]),
      .phase_w_high_drive(hl[5]), .phase_u_low_drive(hl[0]),
      .phase_v_low_drive(hl[1]), .phase_w_low_drive(hl[2]),
      .gate_drive_oe(oe), .speed_filtered_out(sfo), .drive_mode(dm));
   // ==========================================================
   // Expected run drives {hi, lo} per step
   function automatic logic [7:0] exp_run(input logic [2:0] s);
      logic [2:0] h;
      logic [2:0] l;
      h = (s < 2) ? 3'h1 : (s < 4) ? 3'h2 : 3'h4;
      l = (s == 0 || s == 5) ? 3'h2 : (s < 3) ? 3'h4 : 3'h1;
      return {2'h0, h, l};
   endfunction : exp_run
   function automatic logic [31:0] xs(input logic [31:0] v);
      v ^= v << 13;
      v ^= v >> 17;
      v ^= v << 5;
      return v;
   endfunction : xs
   task automatic chk(input string n, input logic [7:0] e);
      checked++;
      if ({2'h0, hl} !== e)
      begin
         $display("ERROR %s expected %h seen %h", n, e, hl);
         num_errors++;
      end
   endtask : chk
   task automatic chkv(input string n, input logic [7:0] e,
      input logic [7:0] s);
      checked++;
      if (s !== e)
      begin
         $display("ERROR %s expected %h seen %h", n, e, s);
         num_errors++;
      end
   endtask : chkv
   task automatic tick(input int n);
      repeat (n) @(negedge sys_clk);
   endtask : tick
   // Register access; read data sampled in the cycle after the strobe
   task automatic reg_io(input logic w, input logic [3:0] a,
      input logic [7:0] d);
      @(posedge sys_clk);
      ra <= a;
      wd <= d;
      wr <= w;
      rd <= !w;
      @(posedge sys_clk);
      wr <= 0;
      rd <= 0;
      @(negedge sys_clk);
      checked++;
      if (!w && rdat !== d)
      begin
         $display("ERROR reg %h expected %h seen %h", a, d, rdat);
         num_errors++;
      end
   endtask : reg_io
   task automatic complete_run;
      $display("checks %0d mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : complete_run
   // ==========================================================
   // Watchdog well beyond the few hundred cycles needed
   initial
   begin
      #2000000;
      num_errors++;
      complete_run();
   end
   // ==========================================================
   // Main sequence
   initial
   begin
      repeat (6) @(posedge sys_clk);
      rst_b <= 1;
      tick(1);
      chk("reset", 8'h00);
      reg_io(0, 4'h0, 8'h01);
      reg_io(0, 4'h8, 8'h00);
      reg_io(1, 4'h0, 8'hff);
      reg_io(0, 4'h0, 8'h03);
      reg_io(1, 4'h0, 8'h01);
      $display("end registers");
      tick(8);
      // Random steps, each a real change, undervoltage mixed in
      repeat (20)
      begin
         rs = xs(rs);
         @(posedge sys_clk);
         pos <= (pos + 3'(1 + rs[7:0] % 5)) % 6;
         uv <= rs[9];
         duty <= 0;
         tick(3);
         chk("run", uv ? exp_run(pos) & 8'h07 : exp_run(pos));
      end
      uv <= 0;
      bad <= 1;
      tick(3);
      chk("hall invalid", 8'h00);
      bad <= 0;
      $display("end run");
      tick(40);
      chk("before lock", exp_run(pos));
      tick(20);
      chk("locked", exp_run(pos) & 8'h07);
      brake_n <= 0;
      tick(2);
      chk("brake guard", 8'h00);
      tick(70);
      chk("braking", 8'h38);
      brake_n <= 1;
      tick(2);
      chk("release guard", 8'h00);
      stp <= 1;
      tick(12);
      checked++;
      if (oe !== 1'b0)
      begin
         $display("ERROR stop oe expected 0 seen %b", oe);
         num_errors++;
      end
      stp <= 0;
      tick(8);
      chk("stop clear", exp_run(pos));
      tick(60);
      chk("relocked", exp_run(pos) & 8'h07);
      duty <= 1;
      tick(25);
      @(posedge sys_clk);
      pos <= (pos + 1) % 6;
      duty <= 0;
      tick(3);
      chk("zero duty clear", exp_run(pos));
      ot <= 1;
      tick(2);
      chk("overtemp", exp_run(pos) & 8'h07);
      ot <= 0;
      cl <= 1;
      tick(2);
      chk("current limit", exp_run(pos) & 8'h07);
      cl <= 0;
      rgs <= 0;
      duty <= 1;
      spd <= 1;
      tick(3);
      chk("reverse zero duty", 8'h00);
      duty <= 0;
      ltp <= 0;
      tick(3);
      chk("timer pin", 8'h00);
      chkv("mode", {5'h00, blp_m_reset}, {5'h00, dm});
      chkv("speed filtered", 8'h01, {7'h00, sfo});
      $display("end protection");
      complete_run();
   end
endmodule : bldc_protection_brake_logic_tb_top
